// File: tb/hcfi_cmd_input_tb_top.sv
// Self-checking bench for the host command FIFO input block
`timescale 1ns/1ns
`default_nettype none
`include "hcfi_params.svh"
module hcfi_cmd_input_tb_top;
	typedef struct {logic [13:0] a; logic [31:0] v;} hcfi_row_s;
	logic CLK, RST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, DMA_READ, DMA_WAITREQUEST;
	logic [13:0] AVS_ADDRESS;
	logic [31:0] AVS_WRITEDATA, AVS_READDATA, DMA_ADDRESS, DMA_READDATA, CTRL_WR_DATA, q;
	logic [3:0] AVS_BYTEENABLE, CTRL_WR_TAG, mem_delay;
	logic BUS_MASTER_CAPABLE, CTRL_WR_VALID, CLEAR_GO, CLEAR_RMW, PIXEL_VALID, PIPE_READY;
	logic [7:0] UNIT_ENABLE, UNIT_READ_REQ, MEM_READ_REQ;
	logic [15:0] PIXEL_X, PIXEL_Y;
	logic [35:0] got_q[$], exp_q[$];
	logic rmw_q[$];
	hcfi_row_s rows[9];
	int errors, checks_done, cyc;
	hcfi_cmd_input #(.FIFO_DEPTH(16), .UNITS(8)) dut (.CLK(CLK), .RST_N(RST_N),
		.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
		.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
		.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
		.DMA_ADDRESS(DMA_ADDRESS), .DMA_READ(DMA_READ), .DMA_READDATA(DMA_READDATA),
		.DMA_WAITREQUEST(DMA_WAITREQUEST), .BUS_MASTER_CAPABLE(BUS_MASTER_CAPABLE),
		.CTRL_WR_VALID(CTRL_WR_VALID), .CTRL_WR_TAG(CTRL_WR_TAG), .CTRL_WR_DATA(CTRL_WR_DATA),
		.UNIT_ENABLE(UNIT_ENABLE), .UNIT_READ_REQ(UNIT_READ_REQ), .MEM_READ_REQ(MEM_READ_REQ),
		.CLEAR_GO(CLEAR_GO), .CLEAR_RMW(CLEAR_RMW), .PIXEL_VALID(PIXEL_VALID),
		.PIXEL_X(PIXEL_X), .PIXEL_Y(PIXEL_Y), .PIPE_READY(PIPE_READY));
	hcfi_host_mem u_mem (.clk(CLK), .rst_n(RST_N), .address(DMA_ADDRESS), .read(DMA_READ),
		.delay(mem_delay), .readdata(DMA_READDATA), .waitrequest(DMA_WAITREQUEST));
	initial
	begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end
	always @(posedge CLK)
	begin
		if (CTRL_WR_VALID === 1'b1)
			got_q.push_back({CTRL_WR_TAG, CTRL_WR_DATA});
		if (CLEAR_GO === 1'b1)
			rmw_q.push_back(CLEAR_RMW);
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			test_done();
		end
	end
	task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : check_val
	// Host holds the request until accepted, so a stalled write is retried as is
	task automatic avs(input logic wr, input logic [13:0] a, input logic [31:0] d);
		AVS_ADDRESS <= a;
		AVS_WRITE <= wr;
		AVS_READ <= !wr;
		AVS_WRITEDATA <= d;
		@(posedge CLK);
		while (AVS_WAITREQUEST !== 1'b0)
			@(posedge CLK);
		q = AVS_READDATA;
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
		@(posedge CLK);
	endtask : avs
	task automatic check_stream();
		int n;
		logic [35:0] g, e;
		n = 0;
		while (got_q.size() < exp_q.size() && n < 300)
		begin
			@(posedge CLK);
			n++;
		end
		repeat (4) @(posedge CLK);
		check_val("load count", exp_q.size(), got_q.size());
		while (exp_q.size() > 0 && got_q.size() > 0)
		begin
			e = exp_q.pop_front();
			g = got_q.pop_front();
			check_val("load tag", {28'h0, e[35:32]}, {28'h0, g[35:32]});
			check_val("load data", e[31:0], g[31:0]);
		end
		exp_q.delete();
		got_q.delete();
	endtask : check_stream
	task automatic test_done();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : test_done
	initial
	begin
		RST_N = 1'b0;
		AVS_ADDRESS = 14'h0;
		AVS_READ = 1'b0;
		AVS_WRITE = 1'b0;
		AVS_WRITEDATA = 32'h0;
		AVS_BYTEENABLE = 4'hF;
		BUS_MASTER_CAPABLE = 1'b0;
		UNIT_READ_REQ = 8'h00;
		PIPE_READY = 1'b1;
		PIXEL_VALID = 1'b0;
		PIXEL_X = 16'h0;
		PIXEL_Y = 16'h0;
		mem_delay = 4'h3;
		u_mem.mem[8] = 32'h00000009;
		u_mem.mem[9] = 32'hDEADBEEF;
		rows = '{'{`HCFI_REG_CTRL, 32'h0}, '{`HCFI_REG_FREE, 32'h00000010},
			'{`HCFI_REG_FMC, 32'h0}, '{`HCFI_REG_DMA_CNT, 32'h0},
			'{`HCFI_REG_EXT_MIN, 32'hFFFFFFFF}, '{`HCFI_REG_EXT_MAX, 32'h0},
			'{`HCFI_REG_STATUS, 32'h0}, '{14'h0040, 32'h0}, '{`HCFI_WIN_LO, 32'h0}};
		repeat (2) @(posedge CLK);
		RST_N <= 1'b1;
		@(posedge CLK);
		foreach (rows[i])
		begin
			avs(1'b0, rows[i].a, 32'h0);
			check_val("register", rows[i].v, q);
		end
		// Address word then data, ascending through the window
		avs(1'b1, `HCFI_WIN_LO, 32'h00000002);
		avs(1'b1, 14'h2004, 32'h12345678);
		exp_q.push_back({4'h2, 32'h12345678});
		check_stream();
		for (int i = 0; i < 5; i++)
			avs(1'b1, 14'h2008 + 14'(4 * i), (i == 0) ? 32'h00000105 : 32'hA0 + 32'(i));
		for (int i = 0; i < 4; i++)
			exp_q.push_back({4'(4 + i), 32'hA1 + 32'(i)});
		check_stream();
		// Repeat group ends on the top word of the window
		for (int i = 0; i < 4; i++)
			avs(1'b1, 14'h2FF0 + 14'(4 * i), (i == 0) ? 32'h00030203 : 32'hB0 + 32'(i));
		for (int i = 1; i < 4; i++)
			exp_q.push_back({4'h3, 32'hB0 + 32'(i)});
		check_stream();
		avs(1'b1, 14'h2000, 32'h0);
		avs(1'b1, 14'h2004, 32'h00000005);
		// Reserved mode code is taken as a single load
		avs(1'b1, 14'h2008, 32'h00000302);
		avs(1'b1, 14'h200C, 32'h00000077);
		exp_q.push_back({4'h0, 32'h5});
		exp_q.push_back({4'h2, 32'h77});
		check_stream();
		check_val("unit enable", 32'h5, {24'h0, UNIT_ENABLE});
		UNIT_READ_REQ <= 8'hFF;
		repeat (3) @(posedge CLK);
		check_val("mem read", 32'h5, {24'h0, MEM_READ_REQ});
		UNIT_READ_REQ <= 8'h00;
		// Full mask clear, then depth-only clear
		for (int i = 0; i < 2; i++)
		begin
			avs(1'b1, 14'h2000, 32'h1);
			avs(1'b1, 14'h2004, (i == 0) ? `HCFI_CLEAR_ALL : 32'h0000FFFF);
			avs(1'b1, 14'h2008, 32'hF);
			avs(1'b1, 14'h200C, 32'h0);
		end
		repeat (10) @(posedge CLK);
		check_val("clear count", 32'h2, rmw_q.size());
		check_val("clear write", 32'h0, {31'h0, rmw_q[0]});
		check_val("clear rmw", 32'h1, {31'h0, rmw_q[1]});
		got_q.delete();
		// Extent recording of two pixels
		avs(1'b1, `HCFI_REG_CTRL, 32'h2);
		PIXEL_VALID <= 1'b1;
		PIXEL_X <= 16'd10;
		PIXEL_Y <= 16'd30;
		@(posedge CLK);
		PIXEL_X <= 16'd5;
		PIXEL_Y <= 16'd20;
		@(posedge CLK);
		PIXEL_VALID <= 1'b0;
		@(posedge CLK);
		avs(1'b0, `HCFI_REG_EXT_MIN, 32'h0);
		check_val("extent min", 32'h00140005, q);
		avs(1'b0, `HCFI_REG_EXT_MAX, 32'h0);
		check_val("extent max", 32'h001E000A, q);
		// No DMA without bus master capability
		avs(1'b1, `HCFI_REG_DMA_ADDR, 32'h20);
		avs(1'b1, `HCFI_REG_DMA_CNT, 32'h2);
		repeat (20) @(posedge CLK);
		check_val("dma idle loads", 32'h0, got_q.size());
		BUS_MASTER_CAPABLE <= 1'b1;
		@(posedge CLK);
		avs(1'b0, `HCFI_REG_FMC, 32'h0);
		check_val("fmc capable", 32'h02000000, q);
		avs(1'b1, `HCFI_REG_DMA_ADDR, 32'h20);
		avs(1'b1, `HCFI_REG_DMA_CNT, 32'h2);
		exp_q.push_back({4'h9, 32'hDEADBEEF});
		check_stream();
		// Stalled pipeline fills the FIFO: one write is dropped, then one is held
		PIPE_READY <= 1'b0;
		for (int i = 0; i < 16; i++)
			avs(1'b1, 14'h2000 + 14'(4 * i), i[0] ? 32'hC0 + 32'(i) : 32'h2);
		avs(1'b0, `HCFI_REG_FREE, 32'h0);
		check_val("free when full", 32'h0, q);
		avs(1'b1, 14'h2040, 32'h2);
		avs(1'b0, `HCFI_REG_STATUS, 32'h0);
		check_val("overflow flag", 32'h1, q);
		avs(1'b1, `HCFI_REG_CTRL, 32'h1);
		fork
			avs(1'b1, 14'h2044, 32'h3);
			begin
				repeat (30) @(posedge CLK);
				check_val("held write", 32'h1, {31'h0, AVS_WAITREQUEST});
				PIPE_READY <= 1'b1;
			end
		join
		avs(1'b1, 14'h2048, 32'hE0);
		for (int i = 0; i < 8; i++)
			exp_q.push_back({4'h2, 32'hC1 + 32'(2 * i)});
		exp_q.push_back({4'h3, 32'hE0});
		check_stream();
		// Reset in mid-run clears the control register
		avs(1'b1, `HCFI_REG_CTRL, 32'h3);
		RST_N <= 1'b0;
		repeat (2) @(posedge CLK);
		RST_N <= 1'b1;
		@(posedge CLK);
		avs(1'b0, `HCFI_REG_CTRL, 32'h0);
		check_val("ctrl after reset", `HCFI_CTRL_RST, q);
		test_done();
	end
endmodule : hcfi_cmd_input_tb_top
`default_nettype wire

// File: tb/hcfi_host_mem.sv
// Host memory model answering the block's DMA read master
`timescale 1ns/1ns
`default_nettype none
module hcfi_host_mem (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [31:0] address,
	input wire logic read,
	input wire logic [3:0] delay,
	output logic [31:0] readdata,
	output logic waitrequest
);
	logic [31:0] mem [0:63];
	logic [3:0] cnt_reg;
	// Data toggles outside an answer so a stale word can never match
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			waitrequest <= 1'b1;
			cnt_reg <= 4'h0;
			readdata <= 32'h0;
		end
		else if (read && waitrequest && cnt_reg == delay)
		begin
			waitrequest <= 1'b0;
			cnt_reg <= 4'h0;
			readdata <= mem[address[7:2]];
		end
		else
		begin
			waitrequest <= 1'b1;
			cnt_reg <= (read && waitrequest) ? cnt_reg + 4'h1 : 4'h0;
			readdata <= ~readdata;
		end
	end
endmodule : hcfi_host_mem
`default_nettype wire

// File: verilog/hcfi_cmd_input.sv
// Host command FIFO input: register slave, aliased FIFO window, DMA and decoder
// Contract
// - Whole 0x2000-0x2FFF window enqueues into FIFO
// - Full FIFO with disconnect: stall, never drop
// - Free entry count readable by host
// - Bit 25 shows bus master capability
// - DMA fetches host memory into FIFO
// - Address word then one data word
// - Indexed address word loads whole register group
// - Repeat mode sends many words one register
// - Each unit enable bit gates its work
// - Control registers change only by FIFO writes
// - Track readable bounding box of rendered pixels
// - Depth-only clear read-modify-write, full clear write
//
// Our own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
`include "hcfi_params.svh"
module hcfi_cmd_input #(
	parameter int FIFO_DEPTH = 16,
	parameter int UNITS = 8
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [13:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	output logic [31:0] DMA_ADDRESS,
	output logic DMA_READ,
	input wire logic [31:0] DMA_READDATA,
	input wire logic DMA_WAITREQUEST,
	input wire logic BUS_MASTER_CAPABLE,
	output logic CTRL_WR_VALID,
	output logic [3:0] CTRL_WR_TAG,
	output logic [31:0] CTRL_WR_DATA,
	output logic [UNITS-1:0] UNIT_ENABLE,
	input wire logic [UNITS-1:0] UNIT_READ_REQ,
	input wire logic PIPE_READY,
	output logic [UNITS-1:0] MEM_READ_REQ,
	output logic CLEAR_GO,
	output logic CLEAR_RMW,
	input wire logic PIXEL_VALID,
	input wire logic [15:0] PIXEL_X,
	input wire logic [15:0] PIXEL_Y
);
	if (UNITS < 1 || UNITS > 32)
	begin : g_bad_units
		$error("hcfi_cmd_input: UNITS must lie in 1..32");
	end

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = new_v[i*8 +: 8];
		return r;
	endfunction : merge_bytes

	hcfi_fifo_if #(.CW($clog2(FIFO_DEPTH) + 1)) fif ();
	hcfi_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo (.clk(CLK), .rst_n(RST_N), .f(fif.store));

	logic wait_reg;
	logic [31:0] ctrl_reg;
	logic ovf_reg;
	logic capable_reg;
	logic [31:0] rd_mux;
	logic req;
	logic in_win;
	logic stall_full;
	logic take;
	logic pio_push;
	logic pio_drop;
	logic wr_take;

	assign req = (AVS_READ || AVS_WRITE) && wait_reg;
	assign in_win = (AVS_ADDRESS >= `HCFI_WIN_LO) && (AVS_ADDRESS <= `HCFI_WIN_HI);
	// Disconnect holds waitrequest; the master keeps retrying the same write
	assign stall_full = AVS_WRITE && in_win && fif.full && ctrl_reg[`HCFI_CTRL_DISC_BIT];
	assign take = req && !stall_full;
	assign wr_take = take && AVS_WRITE;
	assign pio_push = wr_take && in_win && !fif.full;
	assign pio_drop = wr_take && in_win && fif.full;

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			wait_reg <= 1'b1;
		else
			wait_reg <= !take;
	end
	assign AVS_WAITREQUEST = wait_reg;

	// Strap is sampled continuously so it is never taken under reset
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			capable_reg <= 1'b0;
		else
			capable_reg <= BUS_MASTER_CAPABLE;
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			ctrl_reg <= `HCFI_CTRL_RST;
		else if (wr_take && AVS_ADDRESS == `HCFI_REG_CTRL)
			ctrl_reg <= merge_bytes(ctrl_reg, AVS_WRITEDATA, AVS_BYTEENABLE) & `HCFI_CTRL_MASK;
	end

	// Dropped write without disconnect; a new drop beats the clear
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			ovf_reg <= 1'b0;
		else if (pio_drop)
			ovf_reg <= 1'b1;
		else if (wr_take && AVS_ADDRESS == `HCFI_REG_STATUS && AVS_BYTEENABLE[0]
			&& AVS_WRITEDATA[`HCFI_STAT_OVF_BIT])
			ovf_reg <= 1'b0;
	end

	hcfi_pkg::hcfi_dma_e dma_state_reg;
	logic [31:0] dma_addr_reg;
	logic [31:0] dma_cnt_reg;
	hcfi_pkg::hcfi_word_t dma_data_reg;
	logic dma_read_reg;
	logic dma_push;
	logic dma_idle;

	assign dma_idle = (dma_state_reg == hcfi_pkg::HCFI_DMA_IDLE);
	// Programmed writes win the single push port; DMA waits a cycle
	assign dma_push = (dma_state_reg == hcfi_pkg::HCFI_DMA_PUSH) && !pio_push && !fif.full;
	assign fif.push = pio_push || dma_push;
	assign fif.push_data = pio_push ? AVS_WRITEDATA : dma_data_reg;

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			dma_state_reg <= hcfi_pkg::HCFI_DMA_IDLE;
			dma_addr_reg <= 32'h00000000;
			dma_cnt_reg <= 32'h00000000;
			dma_data_reg <= 32'h00000000;
			dma_read_reg <= 1'b0;
		end
		else
		begin
			case (dma_state_reg)
				hcfi_pkg::HCFI_DMA_IDLE:
				begin
					if (wr_take && AVS_ADDRESS == `HCFI_REG_DMA_ADDR)
						dma_addr_reg <= merge_bytes(dma_addr_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
					if (wr_take && AVS_ADDRESS == `HCFI_REG_DMA_CNT)
					begin
						dma_cnt_reg <= merge_bytes(dma_cnt_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
						if (capable_reg && merge_bytes(dma_cnt_reg, AVS_WRITEDATA,
							AVS_BYTEENABLE) != 32'h00000000)
						begin
							dma_state_reg <= hcfi_pkg::HCFI_DMA_READ;
							dma_read_reg <= 1'b1;
						end
					end
				end
				hcfi_pkg::HCFI_DMA_READ:
				begin
					if (!DMA_WAITREQUEST)
					begin
						dma_data_reg <= DMA_READDATA;
						dma_read_reg <= 1'b0;
						dma_addr_reg <= dma_addr_reg + `HCFI_WORD_STEP;
						dma_cnt_reg <= dma_cnt_reg - 32'h00000001;
						dma_state_reg <= hcfi_pkg::HCFI_DMA_PUSH;
					end
				end
				hcfi_pkg::HCFI_DMA_PUSH:
				begin
					if (dma_push)
					begin
						if (dma_cnt_reg != 32'h00000000)
						begin
							dma_state_reg <= hcfi_pkg::HCFI_DMA_READ;
							dma_read_reg <= 1'b1;
						end
						else
							dma_state_reg <= hcfi_pkg::HCFI_DMA_IDLE;
					end
				end
				default:
				begin
					dma_state_reg <= hcfi_pkg::HCFI_DMA_IDLE;
					dma_read_reg <= 1'b0;
				end
			endcase
		end
	end
	assign DMA_ADDRESS = dma_addr_reg;
	assign DMA_READ = dma_read_reg;

	hcfi_pkg::hcfi_dec_e dec_state_reg;
	hcfi_pkg::hcfi_mode_e mode_reg;
	logic [3:0] cur_tag_reg;
	logic [15:0] remain_reg;
	logic [31:0] file_reg [16];
	logic do_pop;
	hcfi_pkg::hcfi_mode_e word_mode;
	logic [15:0] word_cnt;

	// Pipeline backpressure is what lets the FIFO fill up
	assign do_pop = !fif.empty && PIPE_READY;
	assign fif.pop = do_pop;
	assign word_mode = hcfi_pkg::hcfi_mode_e'(fif.pop_data[`HCFI_CMD_MODE_LSB +: 2]);
	assign word_cnt = fif.pop_data[`HCFI_CMD_CNT_LSB +: 16];

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			dec_state_reg <= hcfi_pkg::HCFI_DEC_ADDR;
			mode_reg <= hcfi_pkg::HCFI_MODE_SINGLE;
			cur_tag_reg <= 4'h0;
			remain_reg <= 16'h0000;
		end
		else if (do_pop)
		begin
			case (dec_state_reg)
				hcfi_pkg::HCFI_DEC_ADDR:
				begin
					mode_reg <= word_mode;
					dec_state_reg <= hcfi_pkg::HCFI_DEC_DATA;
					cur_tag_reg <= fif.pop_data[`HCFI_CMD_TAG_MSB:0];
					case (word_mode)
						hcfi_pkg::HCFI_MODE_INDEXED:
						begin
							cur_tag_reg <= fif.pop_data[`HCFI_CMD_TAG_MSB:0] & `HCFI_GROUP_MASK;
							remain_reg <= `HCFI_GROUP_SIZE;
						end
						hcfi_pkg::HCFI_MODE_REPEAT:
							remain_reg <= (word_cnt == 16'h0000) ? 16'h0001 : word_cnt;
						default:
							remain_reg <= 16'h0001;
					endcase
				end
				hcfi_pkg::HCFI_DEC_DATA:
				begin
					remain_reg <= remain_reg - 16'h0001;
					if (mode_reg == hcfi_pkg::HCFI_MODE_INDEXED)
						cur_tag_reg <= cur_tag_reg + 4'h1;
					if (remain_reg == 16'h0001)
						dec_state_reg <= hcfi_pkg::HCFI_DEC_ADDR;
				end
				default:
					dec_state_reg <= hcfi_pkg::HCFI_DEC_ADDR;
			endcase
		end
	end

	logic data_pop;
	assign data_pop = do_pop && dec_state_reg == hcfi_pkg::HCFI_DEC_DATA;

	// Held values survive between primitives; only data words rewrite them
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			for (int i = 0; i < 16; i++)
				file_reg[i] <= 32'h00000000;
		end
		else if (data_pop)
			file_reg[cur_tag_reg] <= fif.pop_data;
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			CTRL_WR_VALID <= 1'b0;
			CTRL_WR_TAG <= 4'h0;
			CTRL_WR_DATA <= 32'h00000000;
		end
		else
		begin
			CTRL_WR_VALID <= data_pop;
			if (data_pop)
			begin
				CTRL_WR_TAG <= cur_tag_reg;
				CTRL_WR_DATA <= fif.pop_data;
			end
		end
	end
	assign UNIT_ENABLE = file_reg[`HCFI_TAG_UNIT_EN][UNITS-1:0];

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			MEM_READ_REQ <= '0;
		else
			MEM_READ_REQ <= UNIT_READ_REQ & UNIT_ENABLE;
	end

	// Partial plane mask must preserve the other planes, hence the read
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			CLEAR_GO <= 1'b0;
			CLEAR_RMW <= 1'b0;
		end
		else
		begin
			CLEAR_GO <= data_pop && cur_tag_reg == `HCFI_TAG_CLEAR_CMD;
			if (data_pop && cur_tag_reg == `HCFI_TAG_CLEAR_CMD)
				CLEAR_RMW <= file_reg[`HCFI_TAG_CLEAR_MASK] != `HCFI_CLEAR_ALL;
		end
	end

	logic [15:0] min_x_reg;
	logic [15:0] min_y_reg;
	logic [15:0] max_x_reg;
	logic [15:0] max_y_reg;
	logic ext_clear;
	assign ext_clear = wr_take && (AVS_ADDRESS == `HCFI_REG_EXT_MIN
		|| AVS_ADDRESS == `HCFI_REG_EXT_MAX);

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			min_x_reg <= `HCFI_EXT_MIN_RST;
			min_y_reg <= `HCFI_EXT_MIN_RST;
			max_x_reg <= `HCFI_EXT_MAX_RST;
			max_y_reg <= `HCFI_EXT_MAX_RST;
		end
		else if (ext_clear)
		begin
			min_x_reg <= `HCFI_EXT_MIN_RST;
			min_y_reg <= `HCFI_EXT_MIN_RST;
			max_x_reg <= `HCFI_EXT_MAX_RST;
			max_y_reg <= `HCFI_EXT_MAX_RST;
		end
		else if (PIXEL_VALID && ctrl_reg[`HCFI_CTRL_EXT_BIT])
		begin
			if (PIXEL_X < min_x_reg)
				min_x_reg <= PIXEL_X;
			if (PIXEL_Y < min_y_reg)
				min_y_reg <= PIXEL_Y;
			if (PIXEL_X > max_x_reg)
				max_x_reg <= PIXEL_X;
			if (PIXEL_Y > max_y_reg)
				max_y_reg <= PIXEL_Y;
		end
	end

	always_comb
	begin
		rd_mux = 32'h00000000;
		case (AVS_ADDRESS)
			`HCFI_REG_CTRL: rd_mux = ctrl_reg;
			`HCFI_REG_FREE: rd_mux = 32'(fif.free_count);
			`HCFI_REG_FMC: rd_mux[`HCFI_FMC_DMA_BIT] = capable_reg;
			`HCFI_REG_DMA_ADDR: rd_mux = dma_addr_reg;
			`HCFI_REG_DMA_CNT: rd_mux = dma_cnt_reg;
			`HCFI_REG_EXT_MIN: rd_mux = {min_y_reg, min_x_reg};
			`HCFI_REG_EXT_MAX: rd_mux = {max_y_reg, max_x_reg};
			`HCFI_REG_STATUS:
			begin
				rd_mux[`HCFI_STAT_OVF_BIT] = ovf_reg;
				rd_mux[`HCFI_STAT_DMA_BIT] = !dma_idle;
			end
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			AVS_READDATA <= 32'h00000000;
		else if (take && AVS_READ)
			AVS_READDATA <= rd_mux;
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	AST_WINDOW_ENQ: assert property (req && AVS_WRITE && in_win && !fif.full
		|-> fif.push && fif.push_data == AVS_WRITEDATA ##1 !wait_reg)
		else $error("Window write not enqueued");
	AST_DISC_HOLD: assert property (stall_full && req |-> !fif.push ##1 wait_reg)
		else $error("Full write with disconnect was not held off");
	AST_FREE_READ: assert property (take && AVS_READ && AVS_ADDRESS == `HCFI_REG_FREE
		|=> AVS_READDATA == 32'($past(fif.free_count)) && !wait_reg)
		else $error("Free count read wrong");
	AST_CAP_BIT: assert property (take && AVS_READ && AVS_ADDRESS == `HCFI_REG_FMC
		|=> AVS_READDATA[`HCFI_FMC_DMA_BIT] == $past(capable_reg))
		else $error("Bus master bit read wrong");
	AST_DMA_PUSH: assert property (dma_state_reg == hcfi_pkg::HCFI_DMA_READ
		&& !DMA_WAITREQUEST |=> dma_state_reg == hcfi_pkg::HCFI_DMA_PUSH
		&& dma_data_reg == $past(DMA_READDATA))
		else $error("DMA word not captured");
	AST_SINGLE: assert property (do_pop && dec_state_reg == hcfi_pkg::HCFI_DEC_ADDR
		&& word_mode == hcfi_pkg::HCFI_MODE_SINGLE |=> remain_reg == 16'h0001
		&& cur_tag_reg == $past(fif.pop_data[3:0]))
		else $error("Single load not set up");
	AST_INDEX_STEP: assert property (data_pop && mode_reg == hcfi_pkg::HCFI_MODE_INDEXED
		|=> CTRL_WR_VALID && CTRL_WR_TAG == $past(cur_tag_reg)
		&& cur_tag_reg == $past(cur_tag_reg) + 4'h1)
		else $error("Indexed group did not step");
	AST_REPEAT: assert property (data_pop && mode_reg == hcfi_pkg::HCFI_MODE_REPEAT
		|=> cur_tag_reg == $past(cur_tag_reg) && CTRL_WR_TAG == $past(cur_tag_reg))
		else $error("Repeat target moved");
	AST_UNIT_GATE: assert property (##1 MEM_READ_REQ ==
		($past(UNIT_READ_REQ) & $past(UNIT_ENABLE)))
		else $error("Disabled unit issued a memory read");
	AST_HOLD: assert property (!data_pop |=> $stable(UNIT_ENABLE) && !CTRL_WR_VALID)
		else $error("Control register changed without FIFO data");
	AST_BOX: assert property (PIXEL_VALID && ctrl_reg[`HCFI_CTRL_EXT_BIT] && !ext_clear
		|=> min_x_reg <= $past(PIXEL_X) && max_y_reg >= $past(PIXEL_Y))
		else $error("Bounding box misses pixel");
	AST_CLEAR: assert property (data_pop && cur_tag_reg == `HCFI_TAG_CLEAR_CMD
		|=> CLEAR_GO && CLEAR_RMW == ($past(file_reg[`HCFI_TAG_CLEAR_MASK]) != `HCFI_CLEAR_ALL))
		else $error("Clear mode wrong");
	COV_DISC: cover property (stall_full && req ##1 wait_reg ##[1:40] pio_push);
	COV_DMA_DONE: cover property (dma_push ##1 dma_idle);
	COV_INDEXED: cover property (data_pop && mode_reg == hcfi_pkg::HCFI_MODE_INDEXED
		&& remain_reg == 16'h0001);
	COV_DROP: cover property (pio_drop);
endmodule : hcfi_cmd_input
`default_nettype wire

// File: verilog/hcfi_fifo.sv
// Command input FIFO held in flip-flops
`timescale 1ns/1ns
`default_nettype none
module hcfi_fifo #(
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	hcfi_fifo_if.store f
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
	begin : g_bad_depth
		$error("hcfi_fifo: DEPTH must be a power of two of at least 2");
	end
	hcfi_pkg::hcfi_word_t mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic do_push;
	logic do_pop;
	assign do_push = f.push && !f.full;
	assign do_pop = f.pop && !f.empty;
	// Single write port keeps entries in arrival order
	always_ff @(posedge clk)
	begin
		if (do_push)
			mem_reg[wr_ptr_reg] <= f.push_data;
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (do_push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (do_pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			if (do_push && !do_pop)
				count_reg <= count_reg + 1'b1;
			else if (do_pop && !do_push)
				count_reg <= count_reg - 1'b1;
		end
	end
	assign f.full = (count_reg == (AW+1)'(DEPTH));
	assign f.empty = (count_reg == '0);
	assign f.pop_data = mem_reg[rd_ptr_reg];
	assign f.free_count = (AW+1)'(DEPTH) - count_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_FIFO_ORDER: assert property (do_push && f.empty && !do_pop |=>
		f.pop_data == $past(f.push_data)) else $error("FIFO head is not the word pushed");
endmodule : hcfi_fifo
`default_nettype wire

// File: verilog/hcfi_fifo_if.sv
// Push/pop carrier between the input logic and the command FIFO
`timescale 1ns/1ns
`default_nettype none
interface hcfi_fifo_if #(parameter int CW = 5);
	logic push;
	hcfi_pkg::hcfi_word_t push_data;
	logic full;
	logic pop;
	hcfi_pkg::hcfi_word_t pop_data;
	logic empty;
	logic [CW-1:0] free_count;
	modport store (input push, input push_data, input pop,
		output full, output empty, output pop_data, output free_count);
	modport user (output push, output push_data, output pop,
		input full, input empty, input pop_data, input free_count);
endinterface : hcfi_fifo_if
`default_nettype wire

// File: verilog/hcfi_params.svh
// Constants for the host command FIFO input block
`ifndef HCFI_PARAMS_SVH
`define HCFI_PARAMS_SVH
`define HCFI_WIN_LO 14'h2000
`define HCFI_WIN_HI 14'h2FFF
`define HCFI_REG_CTRL 14'h0000
`define HCFI_REG_FREE 14'h0004
`define HCFI_REG_FMC 14'h0008
`define HCFI_REG_DMA_ADDR 14'h000C
`define HCFI_REG_DMA_CNT 14'h0010
`define HCFI_REG_EXT_MIN 14'h0014
`define HCFI_REG_EXT_MAX 14'h0018
`define HCFI_REG_STATUS 14'h001C
`define HCFI_CTRL_DISC_BIT 0
`define HCFI_CTRL_EXT_BIT 1
`define HCFI_CTRL_MASK 32'h00000003
`define HCFI_CTRL_RST 32'h00000000
`define HCFI_FMC_DMA_BIT 25
`define HCFI_STAT_OVF_BIT 0
`define HCFI_STAT_DMA_BIT 1
`define HCFI_CMD_TAG_MSB 3
`define HCFI_CMD_MODE_LSB 8
`define HCFI_CMD_CNT_LSB 16
`define HCFI_GROUP_SIZE 16'h0004
`define HCFI_GROUP_MASK 4'hC
`define HCFI_TAG_UNIT_EN 4'h0
`define HCFI_TAG_CLEAR_MASK 4'h1
`define HCFI_TAG_CLEAR_CMD 4'hF
`define HCFI_CLEAR_ALL 32'hFFFFFFFF
`define HCFI_EXT_MIN_RST 16'hFFFF
`define HCFI_EXT_MAX_RST 16'h0000
`define HCFI_WORD_STEP 32'h00000004
`endif

// File: verilog/hcfi_pkg.sv
// Types shared by the host command FIFO input block
package hcfi_pkg;
	typedef logic [31:0] hcfi_word_t;
	typedef enum logic [1:0] {
		HCFI_MODE_SINGLE = 2'h0,
		HCFI_MODE_INDEXED = 2'h1,
		HCFI_MODE_REPEAT = 2'h2,
		HCFI_MODE_RSVD = 2'h3
	} hcfi_mode_e;
	typedef enum logic [1:0] {
		HCFI_DEC_ADDR = 2'h1,
		HCFI_DEC_DATA = 2'h2
	} hcfi_dec_e;
	typedef enum logic [2:0] {
		HCFI_DMA_IDLE = 3'h1,
		HCFI_DMA_READ = 3'h2,
		HCFI_DMA_PUSH = 3'h4
	} hcfi_dma_e;
endpackage : hcfi_pkg
